// [dv/gsp_bus_master.sv]
// Two-wire bus master model that talks to the sensor port.
// Assumes a pull-up on sda: sda_in is the resolved wire level.
`timescale 1ns/10ps
module gsp_bus_master (
	// Clock
	input  wire logic  clk_in,
	// Bus pins
	input  wire logic  sda_in,
	output logic       scl_out,
	output logic       sda_low_out,
	// Byte taken by a read
	output logic       got_valid_out,
	output logic [7:0] got_byte_out
);
	// Bus released and idle high at time zero
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
		got_valid_out = 1'b0;
		got_byte_out = 8'h00;
	end

	// Half bit phase; 6 clk stays clear of the port's pin pipeline
	task automatic half();
		repeat (6) @(posedge clk_in);
	endtask

	// Start or repeated start: sda falls while scl is high
	task automatic bus_start();
		sda_low_out <= 1'b0;
		half();
		scl_out <= 1'b1;
		half();
		sda_low_out <= 1'b1;
		half();
		scl_out <= 1'b0;
		half();
	endtask

	// Stop: sda rises while scl is high
	task automatic bus_stop();
		sda_low_out <= 1'b1;
		half();
		scl_out <= 1'b1;
		half();
		sda_low_out <= 1'b0;
		half();
	endtask

	// One bit; data changes only while scl is low
	task automatic bit_io(input logic b, output logic r);
		sda_low_out <= ~b;
		half();
		scl_out <= 1'b1;
		half();
		r = sda_in;
		scl_out <= 1'b0;
		half();
	endtask

	// Byte out, MSB first, then the target's acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// Byte in, closed by a NACK so the target lets go
	task automatic rd_byte(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(1'b1, r);
		got_byte_out <= d;
		got_valid_out <= 1'b1;
		@(posedge clk_in);
		got_valid_out <= 1'b0;
	endtask
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the sensor serial port and sequencer.
// Assumes the bus master model; engines and registers are modelled here.
`timescale 1ns/10ps
module tb_top;
	import gsp_pkg::*;
	localparam int WSTEP = 4;
	typedef struct packed {
		logic [1:0]  k;
		logic [12:0] v;
	} gsp_ev_t;
	localparam logic [1:0] K_W = 2'h0;
	localparam logic [1:0] K_C = 2'h1;
	localparam logic [1:0] K_R = 2'h2;
	localparam logic [1:0] K_S = 2'h3;

	logic       clk_in, rst_n_in, scl, m_low, sda, got_v, led_e, irq_on_als;
	logic [7:0] got_b, wr_data_out, wait_time_setting_in;
	logic       sda_oe_out, wr_strobe_out, irq_clear_out;
	logic [4:0] reg_addr_out, irq_clear_code_out, ret;
	logic       power_on_in, prox_enable_in, gesture_engine_enable_in;
	logic       gesture_mode_flag_in, wait_enable_in, als_enable_in;
	logic       sleep_after_interrupt_in, long_wait_select_in;
	logic       irq_asserted_in, engine_done_in, led_request_in;
	logic       engine_start_out, led_drive_output_out, osc_run_out;
	logic       sda_o, rd_stb, ce;
	gsp_seq_t   seq_state_out, last_st;
	logic [7:0] mem [32];
	logic [7:0] shd [32];
	gsp_ev_t    q [$];
	int         n_errors, n_tests, wcnt, ecnt, n_rd;

	// Open-drain wire with pull-up; the port's drive value is honoured
	assign sda = m_low ? 1'b0 : (sda_oe_out ? sda_o : 1'b1);

	// 100 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	gsp_port_seq #(.WAIT_STEP_CYC(WSTEP)) dut (
		.clk_in, .rst_n_in, .ce_in(ce), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out, .reg_addr_out, .wr_data_out,
		.wr_strobe_out, .rd_data_in(mem[reg_addr_out]),
		.rd_strobe_out(rd_stb),
		.irq_clear_out, .irq_clear_code_out, .power_on_in, .prox_enable_in,
		.gesture_engine_enable_in, .gesture_mode_flag_in, .wait_enable_in,
		.als_enable_in, .sleep_after_interrupt_in, .wait_time_setting_in,
		.long_wait_select_in, .irq_asserted_in, .engine_done_in,
		.led_request_in, .engine_start_out, .seq_state_out,
		.led_drive_output_out, .osc_run_out);

	gsp_bus_master m (.clk_in, .sda_in(sda), .scl_out(scl),
		.sda_low_out(m_low), .got_valid_out(got_v), .got_byte_out(got_b));

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic fail(input string what, input logic [12:0] e, s);
		n_errors++;
		$display("unexpected %s: expected %0h, seen %0h", what, e, s);
	endtask

	task automatic chk(input string what, input logic [12:0] e, s);
		n_tests++;
		if (s !== e)
			fail(what, e, s);
	endtask

	task automatic note(input logic [1:0] k, input logic [12:0] v);
		q.push_back({k, v});
	endtask

	task automatic note_states(input gsp_seq_t s[$]);
		foreach (s[i])
			note(K_S, 13'(s[i]));
	endtask

	// An event seen at the ports must match the oldest note
	task automatic got(input logic [1:0] k, input logic [12:0] v);
		gsp_ev_t e;
		if (q.size() == 0) begin
			n_tests++;
			fail("event", 13'h0, v);
		end else begin
			e = q.pop_front();
			chk("event kind", 13'(e.k), 13'(k));
			chk("event value", e.v, v);
		end
	endtask

	// Bounded wait for all notes to be matched
	task automatic wait_q(input int lim);
		for (int i = 0; i < lim && q.size() != 0; i++)
			@(posedge clk_in);
		if (q.size() != 0) begin
			fail("queue drain", 13'h0, 13'(q.size()));
			stop_test();
		end
	endtask

	// Write transaction with an optional data byte after the command
	task automatic wr_txn(input logic [6:0] a, input logic [7:0] cmd,
		input logic dat, input logic [7:0] d, input logic exp_ack);
		logic ack;
		m.bus_start();
		chk("osc", 13'h1, 13'(osc_run_out));
		m.wr_byte({a, 1'b0}, ack);
		chk("ack", 13'(exp_ack), 13'(ack));
		if (ack) begin
			m.wr_byte(cmd, ack);
			if (dat)
				m.wr_byte(d, ack);
		end
		m.bus_stop();
	endtask

	// One-byte read, plain or after a command and repeated start
	task automatic rd_txn(input logic cmd_first, input logic [7:0] cmd);
		logic       ack;
		logic [7:0] d;
		note(K_R, 13'(shd[ret]));
		m.bus_start();
		if (cmd_first) begin
			m.wr_byte({TARGET_ADDR, 1'b0}, ack);
			m.wr_byte(cmd, ack);
			m.bus_start();
		end
		m.wr_byte({TARGET_ADDR, 1'b1}, ack);
		m.rd_byte(d);
		m.bus_stop();
	endtask

	// Watcher: writes, clears, read bytes, state changes, LED gating
	always @(negedge clk_in) begin
		if (rst_n_in) begin
			if (wr_strobe_out === 1'b1)
				got(K_W, {reg_addr_out, wr_data_out});
			if (irq_clear_out === 1'b1)
				got(K_C, 13'(irq_clear_code_out));
			if (got_v === 1'b1)
				got(K_R, 13'(got_b));
			if (seq_state_out !== last_st) begin
				got(K_S, 13'(seq_state_out));
				if (seq_state_out inside {SQ_PROX, SQ_GEST, SQ_ALS})
					chk("start", 13'h1, 13'(engine_start_out));
				last_st = seq_state_out;
			end
			led_e = led_request_in &&
				(seq_state_out == SQ_PROX || seq_state_out == SQ_GEST);
			chk("led", 13'(led_e), 13'(led_drive_output_out));
		end
	end

	// Engines finish 4 cycles after start; colour end raises interrupt
	always @(posedge clk_in) begin
		engine_done_in <= 1'b0;
		if (wr_strobe_out === 1'b1)
			mem[reg_addr_out] <= wr_data_out;
		if (rd_stb === 1'b1)
			n_rd <= n_rd + 1;
		if (engine_start_out === 1'b1)
			ecnt <= 4;
		else if (ecnt != 0)
			ecnt <= ecnt - 1;
		if (ecnt == 1) begin
			engine_done_in <= 1'b1;
			if (seq_state_out == SQ_ALS && irq_on_als)
				irq_asserted_in <= 1'b1;
		end
		if (irq_clear_out === 1'b1)
			irq_asserted_in <= 1'b0;
		if (seq_state_out == SQ_WAIT)
			wcnt <= wcnt + 1;
		else if (seq_state_out == SQ_PROX)
			wcnt <= 0;
	end

	// Main sequence
	initial begin
		logic [4:0] a;
		logic [7:0] d;
		{rst_n_in, power_on_in, prox_enable_in, gesture_engine_enable_in,
			gesture_mode_flag_in, wait_enable_in, als_enable_in,
			sleep_after_interrupt_in, long_wait_select_in, irq_asserted_in,
			engine_done_in, led_request_in, irq_on_als} = '0;
		wait_time_setting_in = 8'hFD;
		n_errors = 0;
		n_tests = 0;
		wcnt = 0;
		ecnt = 0;
		n_rd = 0;
		ce = 1'b1;
		ret = 5'h00;
		last_st = SQ_SLEEP;
		for (int i = 0; i < 32; i++) begin
			mem[i] = 8'(i) ^ 8'hA5;
			shd[i] = mem[i];
		end
		void'($urandom(32'h7BF6));
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk("state", 13'(SQ_SLEEP), 13'(seq_state_out));
		chk("osc", 13'h0, 13'(osc_run_out));
		// Random writes, each read back by a combined read
		for (int i = 0; i < 4; i++) begin
			a = 5'($urandom);
			d = 8'($urandom);
			note(K_W, {a, d});
			wr_txn(TARGET_ADDR, {3'b100, a}, 1'b1, d, 1'b1);
			shd[a] = d;
			ret = a;
			rd_txn(1'b1, {3'b100, a});
			chk("osc", 13'h0, 13'(osc_run_out));
		end
		// Command with MSB clear keeps the held address
		d = 8'($urandom);
		note(K_W, {ret, d});
		wr_txn(TARGET_ADDR, {1'b0, 7'($urandom)}, 1'b1, d, 1'b1);
		shd[ret] = d;
		rd_txn(1'b0, 8'h00);
		wr_txn(7'h2A, 8'h80, 1'b1, 8'h5A, 1'b0);
		wait_q(50);
		chk("reads", 13'h5, 13'(n_rd));
		// Powered but held asleep, then first wake with all engines
		{prox_enable_in, gesture_engine_enable_in, gesture_mode_flag_in,
			wait_enable_in, als_enable_in} <= '1;
		{sleep_after_interrupt_in, irq_asserted_in, irq_on_als} <= '1;
		{led_request_in, power_on_in} <= '1;
		repeat (20) @(posedge clk_in);
		chk("osc", 13'h1, 13'(osc_run_out));
		note_states({SQ_PAUSE, SQ_PROX, SQ_GEST, SQ_WAIT, SQ_ALS,
			SQ_SLEEP});
		irq_asserted_in <= 1'b0;
		wait_q(400);
		repeat (5) @(posedge clk_in);
		chk("wait", 13'h1, 13'(wcnt >= 12 && wcnt <= 16));
		chk("held addr", 13'(ret), 13'(reg_addr_out));
		// Clear command wakes without pause; gesture mode off, long wait
		gesture_mode_flag_in <= 1'b0;
		long_wait_select_in <= 1'b1;
		note(K_C, 13'h05);
		note_states({SQ_IDLE, SQ_PROX, SQ_WAIT, SQ_ALS, SQ_SLEEP});
		wr_txn(TARGET_ADDR, 8'hE5, 1'b0, 8'h00, 1'b1);
		wait_q(800);
		repeat (5) @(posedge clk_in);
		chk("wait", 13'h1, 13'(wcnt >= 144 && wcnt <= 148));
		// Sleep bit clear ends sleep; nothing enabled stays idle
		{prox_enable_in, gesture_engine_enable_in, wait_enable_in,
			als_enable_in} <= '0;
		note(K_S, 13'(SQ_IDLE));
		sleep_after_interrupt_in <= 1'b0;
		wait_q(50);
		repeat (30) @(posedge clk_in);
		chk("state", 13'(SQ_IDLE), 13'(seq_state_out));
		// Enable low freezes the sequencer even as power drops
		ce <= 1'b0;
		power_on_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk("frozen", 13'(SQ_IDLE), 13'(seq_state_out));
		note(K_S, 13'(SQ_SLEEP));
		ce <= 1'b1;
		wait_q(50);
		stop_test();
	end
endmodule

// [include/gsp_pkg.sv]
// Shared constants and types for the sensor serial port and sequencer.
// Assumes a 100 MHz core clock; bus pins are sampled as synchronous levels.
package gsp_pkg;

	// Core clock
	localparam int          CLK_PERIOD_NS   = 10;

	// Bus target address and command byte layout
	localparam logic [6:0]  TARGET_ADDR     = 7'h39;
	localparam int          CMD_FLAG_BIT    = 7;
	localparam int          CMD_TYPE_MSB    = 6;
	localparam int          CMD_TYPE_LSB    = 5;
	localparam logic [1:0]  CMD_TYPE_REG    = 2'h0;
	localparam logic [1:0]  CMD_TYPE_SPEC   = 2'h3;
	localparam int          REG_ADDR_W      = 5;
	localparam logic [3:0]  BYTE_BITS       = 4'h8;
	localparam logic [4:0]  REG_ADDR_RST    = 5'h00;

	// Wait engine timing: one step and the long-wait multiplier
	localparam real         WAIT_STEP_MS    = 2.78;
	localparam real         WAIT_MAX_S      = 8.54;
	localparam int          WAIT_STEP_CYC   =
		int'(WAIT_STEP_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam logic [3:0]  LONG_WAIT_MULT  = 4'hC;
	localparam logic [8:0]  WAIT_STEPS_FULL = 9'h100;

	// Exit-sleep pause length in cycles
	localparam int          EXIT_PAUSE_CYC  = 16;

	// Sequencer states
	typedef enum logic [2:0] {
		SQ_SLEEP, SQ_IDLE, SQ_PAUSE, SQ_PROX, SQ_GEST, SQ_WAIT, SQ_ALS
	} gsp_seq_t;

	// Serial port states
	typedef enum logic [2:0] {
		BS_IDLE, BS_ADDR, BS_ACK, BS_WR, BS_RD, BS_RACK
	} gsp_bus_t;

endpackage

// [include/gsp_wait_if.sv]
// Handshake between the sequencer and the wait timer.
// Assumes both ends share the core clock.
`timescale 1ns/10ps
interface gsp_wait_if;
	logic       start;
	logic       done;
	logic [7:0] wait_time;
	logic       long_sel;

	modport seq (output start, output wait_time, output long_sel,
		input done);
	modport tmr (input start, input wait_time, input long_sel,
		output done);
endinterface

// [rtl/gsp_edge.sv]
// Level and edge detector for one synchronous bus pin.
// Assumes the pin is already synchronous to clk_in.
`timescale 1ns/10ps
module gsp_edge (
	// Clock, reset, enable
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	// Pin
	input  wire logic pin_in,
	// Decoded
	output logic      level_out,
	output logic      rise_out,
	output logic      fall_out
);
	logic cur;
	logic prev;

	// Two stages so edges compare registered values only
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cur  <= 1'b1;
			prev <= 1'b1;
		end else if (ce_in) begin
			cur  <= pin_in;
			prev <= cur;
		end
	end

	assign level_out = cur;
	assign rise_out  = cur & ~prev;
	assign fall_out  = ~cur & prev;
endmodule

// [rtl/gsp_port_seq.sv]
// Two-wire target port with command decode, and the operating sequencer.
// Assumes scl/sda are synchronous to clk_in and far slower than it;
// register storage, engines and interrupt logic sit outside this block.
`timescale 1ns/10ps
module gsp_port_seq #(
	parameter int WAIT_STEP_CYC  = gsp_pkg::WAIT_STEP_CYC,
	parameter int EXIT_PAUSE_CYC = gsp_pkg::EXIT_PAUSE_CYC
) (
	// Clock, reset, enable
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     ce_in,
	// Two-wire bus pins
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe_out,
	// Register access toward the register file
	output logic [gsp_pkg::REG_ADDR_W-1:0] reg_addr_out,
	output logic [7:0]                    wr_data_out,
	output logic                          wr_strobe_out,
	input  wire logic [7:0]               rd_data_in,
	output logic                          rd_strobe_out,
	// Interrupt clear commands
	output logic                          irq_clear_out,
	output logic [4:0]                    irq_clear_code_out,
	// Control settings
	input  wire logic                     power_on_in,
	input  wire logic                     prox_enable_in,
	input  wire logic                     gesture_engine_enable_in,
	input  wire logic                     gesture_mode_flag_in,
	input  wire logic                     wait_enable_in,
	input  wire logic                     als_enable_in,
	input  wire logic                     sleep_after_interrupt_in,
	input  wire logic [7:0]               wait_time_setting_in,
	input  wire logic                     long_wait_select_in,
	input  wire logic                     irq_asserted_in,
	// Engine handshake
	input  wire logic                     engine_done_in,
	input  wire logic                     led_request_in,
	output logic                          engine_start_out,
	output gsp_pkg::gsp_seq_t             seq_state_out,
	output logic                          led_drive_output_out,
	output logic                          osc_run_out
);
	import gsp_pkg::*;
	localparam int PW = $clog2(EXIT_PAUSE_CYC + 1);

	gsp_bus_t      bst;
	gsp_seq_t      sst;
	gsp_seq_t      next_sst;
	logic          scl_lvl, scl_rise, scl_fall;
	logic          sda_lvl, sda_rise, sda_fall;
	logic [7:0]    shift;
	logic [7:0]    tx;
	logic [3:0]    cnt;
	logic          rw;
	logic          first;
	logic          clr_pend;
	logic          nbytes;
	logic          ack_drv;
	logic          rd_drv;
	logic          paused_once;
	logic [PW-1:0] pause_cnt;
	logic [3:0]    en;
	logic          sleep_hold;
	logic          bus_start;
	logic          bus_stop;
	gsp_wait_if    wif ();

	// Pin edge detection; 100 MHz sampling covers 400 kHz bus rates
	gsp_edge u_scl (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.ce_in     (ce_in),
		.pin_in    (scl_in),
		.level_out (scl_lvl),
		.rise_out  (scl_rise),
		.fall_out  (scl_fall)
	);
	gsp_edge u_sda (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.ce_in     (ce_in),
		.pin_in    (sda_in),
		.level_out (sda_lvl),
		.rise_out  (sda_rise),
		.fall_out  (sda_fall)
	);

	gsp_wait_timer #(.STEP_CYC(WAIT_STEP_CYC)) u_wait (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.wt       (wif.tmr)
	);

	// Start and stop are sda edges while scl is high
	assign bus_start  = scl_lvl & sda_fall;
	assign bus_stop   = scl_lvl & sda_rise;
	// Open drain: only ever pull low
	assign sda_out    = 1'b0;
	assign sda_oe_out = ack_drv | (rd_drv & ~tx[7]);

	// Serial target: address match, command decode, data in and out
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			bst                <= BS_IDLE;
			shift              <= 8'h00;
			tx                 <= 8'h00;
			cnt                <= 4'h0;
			rw                 <= 1'b0;
			first              <= 1'b0;
			clr_pend           <= 1'b0;
			nbytes             <= 1'b0;
			ack_drv            <= 1'b0;
			rd_drv             <= 1'b0;
			reg_addr_out       <= REG_ADDR_RST;
			wr_data_out        <= 8'h00;
			wr_strobe_out      <= 1'b0;
			rd_strobe_out      <= 1'b0;
			irq_clear_out      <= 1'b0;
			irq_clear_code_out <= 5'h00;
		end else if (ce_in) begin
			wr_strobe_out <= 1'b0;
			rd_strobe_out <= 1'b0;
			irq_clear_out <= 1'b0;
			if (bus_start) begin
				// Repeated start keeps the retained address
				bst      <= BS_ADDR;
				cnt      <= 4'h0;
				first    <= 1'b1;
				clr_pend <= 1'b0;
				nbytes   <= 1'b0;
				ack_drv  <= 1'b0;
				rd_drv   <= 1'b0;
			end else if (bus_stop) begin
				bst     <= BS_IDLE;
				ack_drv <= 1'b0;
				rd_drv  <= 1'b0;
				// Clear only when nothing followed the command
				if (clr_pend && !nbytes) begin
					irq_clear_out <= 1'b1;
				end
				clr_pend <= 1'b0;
			end else begin
				case (bst)
				BS_ADDR, BS_WR: begin
					if (scl_rise) begin
						shift <= {shift[6:0], sda_lvl};
						cnt   <= cnt + 4'h1;
					end else if (scl_fall && cnt == BYTE_BITS) begin
						cnt     <= 4'h0;
						bst     <= BS_ACK;
						ack_drv <= 1'b1;
						if (bst == BS_ADDR) begin
							rw <= shift[0];
							if (shift[7:1] != TARGET_ADDR) begin
								bst     <= BS_IDLE;
								ack_drv <= 1'b0;
							end
						end else if (first) begin
							first <= 1'b0;
							if (shift[CMD_FLAG_BIT]) begin
								if (shift[CMD_TYPE_MSB:CMD_TYPE_LSB]
									== CMD_TYPE_SPEC) begin
									clr_pend           <= 1'b1;
									irq_clear_code_out <= shift[4:0];
								end else begin
									reg_addr_out <= shift[4:0];
								end
							end
						end else begin
							// Data always lands at the retained address
							wr_strobe_out <= 1'b1;
							wr_data_out   <= shift;
							nbytes        <= 1'b1;
						end
					end
				end
				BS_ACK: begin
					if (scl_fall) begin
						ack_drv <= 1'b0;
						cnt     <= 4'h0;
						if (rw) begin
							bst           <= BS_RD;
							tx            <= rd_data_in;
							rd_strobe_out <= 1'b1;
							rd_drv        <= 1'b1;
							nbytes        <= 1'b1;
						end else begin
							bst <= BS_WR;
						end
					end
				end
				BS_RD: begin
					if (scl_fall) begin
						if (cnt == BYTE_BITS - 4'h1) begin
							rd_drv <= 1'b0;
							bst    <= BS_RACK;
						end else begin
							tx  <= {tx[6:0], 1'b0};
							cnt <= cnt + 4'h1;
						end
					end
				end
				BS_RACK: begin
					// Master not-acknowledge ends the read burst
					if (scl_rise && sda_lvl) begin
						bst <= BS_IDLE;
					end else if (scl_fall) begin
						bst           <= BS_RD;
						tx            <= rd_data_in;
						rd_strobe_out <= 1'b1;
						rd_drv        <= 1'b1;
						cnt           <= 4'h0;
					end
				end
				default: bst <= BS_IDLE;
				endcase
			end
		end
	end

	// Oscillator runs when powered, or briefly to serve the bus
	assign osc_run_out = power_on_in | (bst != BS_IDLE);

	// Engine enables in visiting order: prox, gesture, wait, light
	assign en = {als_enable_in, wait_enable_in,
		gesture_engine_enable_in & gesture_mode_flag_in, prox_enable_in};
	assign sleep_hold = sleep_after_interrupt_in & irq_asserted_in;

	// First enabled state after cur; SQ_IDLE marks the cycle end
	function automatic gsp_seq_t next_engine(input gsp_seq_t cur,
		input logic [3:0] e);
		logic [3:0] m;
		m = e;
		case (cur)
		SQ_PROX: m = e & 4'hE;
		SQ_GEST: m = e & 4'hC;
		SQ_WAIT: m = e & 4'h8;
		SQ_ALS:  m = 4'h0;
		default: m = e;
		endcase
		if (m[0])      next_engine = SQ_PROX;
		else if (m[1]) next_engine = SQ_GEST;
		else if (m[2]) next_engine = SQ_WAIT;
		else if (m[3]) next_engine = SQ_ALS;
		else           next_engine = SQ_IDLE;
	endfunction

	// Next sequencer state
	always_comb begin
		next_sst = sst;
		if (!power_on_in) begin
			next_sst = SQ_SLEEP;
		end else begin
			case (sst)
			SQ_SLEEP: begin
				// Held until the interrupt or the sleep bit clears
				if (!sleep_hold) begin
					if (!paused_once && (en[0] | en[1] | en[3]))
						next_sst = SQ_PAUSE;
					else
						next_sst = SQ_IDLE;
				end
			end
			SQ_PAUSE: begin
				if (pause_cnt == PW'(EXIT_PAUSE_CYC - 1))
					next_sst = next_engine(SQ_IDLE, en);
			end
			SQ_IDLE: next_sst = next_engine(SQ_IDLE, en);
			SQ_PROX, SQ_GEST, SQ_WAIT, SQ_ALS: begin
				if ((sst == SQ_WAIT) ? wif.done : engine_done_in) begin
					next_sst = next_engine(sst, en);
					if (next_engine(sst, en) == SQ_IDLE && sleep_hold)
						next_sst = SQ_SLEEP;
				end
			end
			default: next_sst = SQ_SLEEP;
			endcase
		end
	end

	// Sequencer state; sleep touches no setting, it only overrides
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sst <= SQ_SLEEP;
		end else if (ce_in) begin
			sst <= next_sst;
		end
	end

	// Exit-sleep pause count and once-only flag
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pause_cnt   <= '0;
			paused_once <= 1'b0;
		end else if (ce_in) begin
			pause_cnt <= (sst == SQ_PAUSE) ? pause_cnt + PW'(1) : '0;
			if (!power_on_in)
				paused_once <= 1'b0;
			else if (sst == SQ_PAUSE)
				paused_once <= 1'b1;
		end
	end

	// Engine start pulses on entry
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			engine_start_out <= 1'b0;
			wif.start        <= 1'b0;
		end else if (ce_in) begin
			engine_start_out <= (next_sst != sst) && (next_sst == SQ_PROX
				|| next_sst == SQ_GEST || next_sst == SQ_ALS);
			wif.start        <= (next_sst != sst) && (next_sst == SQ_WAIT);
		end
	end

	assign wif.wait_time = wait_time_setting_in;
	assign wif.long_sel  = long_wait_select_in;
	assign seq_state_out = sst;
	// Light engine never reaches the LED
	assign led_drive_output_out = led_request_in &
		(sst == SQ_PROX || sst == SQ_GEST);

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	addr_mismatch_a: assert property (ce_in && bst == BS_ADDR && !bus_start
		&& !bus_stop && scl_fall && cnt == BYTE_BITS
		&& shift[7:1] != TARGET_ADDR |=> !sda_oe_out && bst == BS_IDLE)
		else $error("foreign address acknowledged");
	cmd_address_a: assert property (ce_in && bst == BS_WR && first
		&& !bus_start && !bus_stop && scl_fall && cnt == BYTE_BITS
		&& shift[7:5] == 3'h4 |=> reg_addr_out == $past(shift[4:0]))
		else $error("command address not retained");
	write_addr_a: assert property (wr_strobe_out |->
		$stable(reg_addr_out) && wr_data_out == $past(shift))
		else $error("write used wrong address or data");
	clear_only_a: assert property (irq_clear_out |->
		$past(bus_stop) && !$past(nbytes) && $past(clr_pend))
		else $error("interrupt clear without bare command");
	reset_sleep_a: assert property (disable iff (1'b0)
		!rst_n_in |=> sst == SQ_SLEEP)
		else $error("reset did not enter sleep");
	led_gate_a: assert property (led_drive_output_out |->
		sst == SQ_PROX || sst == SQ_GEST)
		else $error("LED driven outside prox or gesture");
	idle_quiet_a: assert property (ce_in && sst == SQ_IDLE && power_on_in
		&& en == 4'h0 |=> sst == SQ_IDLE && !engine_start_out)
		else $error("idle left with nothing enabled");
	sleep_entry_a: assert property (ce_in && sst != SQ_SLEEP
		&& power_on_in ##1 sst == SQ_SLEEP |-> $past(sleep_hold))
		else $error("sleep entered without cause");
	sleep_exit_a: assert property (ce_in && sst == SQ_SLEEP && power_on_in
		&& !sleep_hold |=> sst != SQ_SLEEP)
		else $error("sleep not left after release");
	order_a: assert property (ce_in && sst == SQ_PROX && engine_done_in
		&& power_on_in && en[1] |=> sst == SQ_GEST && engine_start_out)
		else $error("gesture did not follow proximity");

	clear_c: cover property (irq_clear_out);
	read_c: cover property (rd_strobe_out ##[1:400] rd_strobe_out);
	sleep_c: cover property (sst == SQ_ALS ##1 sst == SQ_SLEEP);
endmodule

// [rtl/gsp_wait_timer.sv]
// Wait-state timer: (256 - setting) steps, each stretched in long mode.
// Assumes start is a one-cycle pulse and is not repeated while counting.
`timescale 1ns/10ps
module gsp_wait_timer #(
	parameter int STEP_CYC = gsp_pkg::WAIT_STEP_CYC
) (
	// Clock, reset, enable
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	// Sequencer side
	gsp_wait_if.tmr   wt
);
	import gsp_pkg::*;
	localparam int SW = $clog2(STEP_CYC + 1);

	logic          busy;
	logic          long_l;
	logic [8:0]    steps;
	logic [3:0]    mult;
	logic [SW-1:0] sub;

	// Step counter; long mode repeats each step LONG_WAIT_MULT times
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			busy    <= 1'b0;
			long_l  <= 1'b0;
			steps   <= 9'h000;
			mult    <= 4'h0;
			sub     <= '0;
			wt.done <= 1'b0;
		end else if (ce_in) begin
			wt.done <= 1'b0;
			if (wt.start) begin
				busy   <= 1'b1;
				long_l <= wt.long_sel;
				steps  <= WAIT_STEPS_FULL - {1'b0, wt.wait_time};
				mult   <= wt.long_sel ? LONG_WAIT_MULT - 4'h1 : 4'h0;
				sub    <= SW'(STEP_CYC - 1);
			end else if (busy) begin
				if (sub != '0) begin
					sub <= sub - SW'(1);
				end else begin
					sub <= SW'(STEP_CYC - 1);
					if (mult != 4'h0) begin
						mult <= mult - 4'h1;
					end else begin
						mult <= long_l ? LONG_WAIT_MULT - 4'h1 : 4'h0;
						if (steps == 9'h001) begin
							busy    <= 1'b0;
							wt.done <= 1'b1;
						end else begin
							steps <= steps - 9'h001;
						end
					end
				end
			end
		end
	end
endmodule
